// >>> design/dbs_bus_master.sv
// Purpose: Bus master that splits operands over 32, 16 and 8 bit ports.
// Assumes: Slave keeps acknowledge until strobes negate; pins are asynchronous.
// Notes:   Every pin input passes two flip-flops, adding two clocks of latency.
`timescale 1ns/1ns
module dbs_bus_master
  import dbs_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Operand request
  input  wire logic        i_req_valid,
  input  wire logic        i_req_write,
  input  wire logic        i_req_instr,
  input  wire logic [1:0]  i_req_size,
  input  wire logic [31:0] i_req_addr,
  input  wire logic [31:0] i_req_wdata,
  output logic             o_req_ready,
  output logic             o_done,
  output logic             o_bus_err,
  output logic             o_addr_err,
  output logic [31:0]      o_rdata,
  // Internal acknowledge option
  input  wire logic        i_int_ack_en,
  input  wire logic [1:0]  i_int_ack_port,
  // External bus
  output logic [31:0]      o_addr,
  output logic [1:0]       o_size_code,
  output logic             o_read_write,
  output logic             o_address_strobe_n,
  output logic             o_data_strobe_n,
  output logic [31:0]      o_data_out,
  output logic             o_data_oe,
  input  wire logic [31:0] i_data_in,
  input  wire logic        i_ack_width_hi_n,
  input  wire logic        i_ack_width_lo_n,
  input  wire logic        i_bus_error_in_n,
  input  wire logic        i_halt_n
);
  dbs_state_t  state_q;
  logic [35:0] sync_m_q, sync_q;
  logic [31:0] addr_q, wbuf_q, acc_q, dout_q, rdata_q, din_sh;
  logic [2:0]  rem_q, req_bytes;
  logic [1:0]  port_q, ack_pair, ack_port;
  logic        rw_q, err_q, retry_q, done_q, bus_err_q, addr_err_q;
  logic        ack_seen, bus_error_in_s, halt_s, req_odd_fetch, finish;

  dbs_split_if sp ();
  dbs_sizer u_sizer (.sp(sp));

  assign sp.addr_lo   = addr_q[1:0];
  assign sp.remaining = rem_q;
  assign sp.port      = port_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      sync_m_q <= '0;
      sync_q   <= '0;
    end else begin
      sync_m_q <= {~i_ack_width_hi_n, ~i_ack_width_lo_n, ~i_bus_error_in_n, ~i_halt_n, i_data_in};
      sync_q   <= sync_m_q;
    end
  end

  always_comb begin
    if (i_int_ack_en) begin
      // Internal responder stands in for the slave
      case (i_int_ack_port)
        PORT_32: ack_pair = 2'h3;
        PORT_16: ack_pair = 2'h2;
        default: ack_pair = 2'h1;
      endcase
    end else begin
      ack_pair = sync_q[35:34];
    end
    case (ack_pair)
      2'h3:    ack_port = PORT_32;
      2'h2:    ack_port = PORT_16;
      default: ack_port = PORT_8;
    endcase
  end
  assign ack_seen = |ack_pair;
  assign bus_error_in_s   = sync_q[33];
  assign halt_s   = sync_q[32];

  ////////////////////////////////////////////////////////////////////////////
  // Request decode
  // Fetches never use the operand size: aligned long, or the odd word alone
  assign req_bytes = i_req_instr ? (i_req_addr[1] ? BYTES_WORD : BYTES_LONG)
                   : (i_req_size == SIZE_LONG) ? BYTES_LONG : {1'b0, i_req_size};
  assign req_odd_fetch = i_req_instr & i_req_addr[0];
  assign finish = (state_q == ST_END) & ~retry_q & (err_q | (rem_q == 3'h0));
  assign din_sh = sync_q[31:0] << {sp.lane, 3'b000};

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (i_req_valid && !req_odd_fetch) begin
            state_q <= ST_ADDR;
          end
        end
        ST_ADDR:   state_q <= ST_SAMPLE;
        ST_SAMPLE: begin
          // No acknowledge means another whole wait clock
          if (bus_error_in_s || ack_seen) begin
            state_q <= bus_error_in_s ? ST_END : ST_LATCH;
          end
        end
        ST_LATCH:  state_q <= ST_END;
        ST_END: begin
          if (retry_q) begin
            if (!halt_s) begin
              state_q <= ST_ADDR;
            end
          end else if (err_q || rem_q == 3'h0) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_ADDR;
          end
        end
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand progress
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      addr_q <= '0;
      rem_q  <= '0;
      rw_q   <= 1'b1;
      wbuf_q <= '0;
      acc_q  <= '0;
      port_q <= PORT_32;
    end else if (state_q == ST_IDLE && i_req_valid && !req_odd_fetch) begin
      addr_q <= i_req_addr;
      rem_q  <= req_bytes;
      rw_q   <= ~(i_req_write & ~i_req_instr);
      wbuf_q <= i_req_wdata << (6'd32 - {req_bytes, 3'b000});
      acc_q  <= '0;
    end else if (state_q == ST_SAMPLE && ack_seen) begin
      port_q <= ack_port;
    end else if (state_q == ST_LATCH && !bus_error_in_s) begin
      // Late bus error one clock after acknowledge discards the transfer
      addr_q <= addr_q + {29'h0, sp.moved};
      rem_q  <= rem_q - sp.moved;
      wbuf_q <= wbuf_q << {sp.moved, 3'b000};
      acc_q  <= (acc_q << {sp.moved, 3'b000}) | (din_sh >> (6'd32 - {sp.moved, 3'b000}));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination flags
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      err_q   <= 1'b0;
      retry_q <= 1'b0;
    end else if (state_q == ST_ADDR) begin
      err_q   <= 1'b0;
      retry_q <= 1'b0;
    end else if ((state_q == ST_SAMPLE || state_q == ST_LATCH) && bus_error_in_s) begin
      err_q   <= 1'b1;
      retry_q <= halt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write lanes and answers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dout_q <= '0;
    end else if (state_q == ST_ADDR) begin
      // Leading byte on the top lane, narrow ports find theirs in the upper half
      dout_q[31:24] <= wbuf_q[31:24];
      dout_q[23:16] <= addr_q[0] ? wbuf_q[31:24] : wbuf_q[23:16];
      dout_q[15:0]  <= 16'(wbuf_q >> {addr_q[1:0], 3'b000});
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      done_q     <= 1'b0;
      bus_err_q  <= 1'b0;
      addr_err_q <= 1'b0;
      rdata_q    <= '0;
    end else begin
      done_q     <= finish;
      bus_err_q  <= finish & err_q;
      addr_err_q <= (state_q == ST_IDLE) & i_req_valid & req_odd_fetch;
      if (finish) begin
        rdata_q <= acc_q;
      end
    end
  end

  assign o_req_ready        = (state_q == ST_IDLE);
  assign o_done             = done_q;
  assign o_bus_err          = bus_err_q;
  assign o_addr_err         = addr_err_q;
  assign o_rdata            = rdata_q;
  assign o_addr             = addr_q;
  assign o_size_code        = rem_q[1:0];
  assign o_read_write       = rw_q;
  // Strobes: address from the start, write data strobe one clock later
  assign o_address_strobe_n = ~(state_q == ST_ADDR || state_q == ST_SAMPLE || state_q == ST_LATCH);
  assign o_data_strobe_n    = o_address_strobe_n | (~rw_q & state_q == ST_ADDR);
  assign o_data_oe          = ~rw_q & (state_q == ST_SAMPLE || state_q == ST_LATCH);
  assign o_data_out         = dout_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [7:0] cyc_q;
  always_ff @(posedge i_clock) begin
    if (i_rst || state_q == ST_END || state_q == ST_IDLE) begin
      cyc_q <= '0;
    end else if (cyc_q != 8'hff) begin
      // Saturates so a very long wait cannot wrap back under the minimum
      cyc_q <= cyc_q + 8'h1;
    end
  end

  chk_odd_fetch_err: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_req_ready && i_req_valid && req_odd_fetch) |=> o_addr_err && o_req_ready)
    else $error("odd instruction fetch did not raise address error");
  chk_fetch_size: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_req_ready && i_req_valid && i_req_instr && !i_req_addr[0])
      |=> o_size_code == ($past(i_req_addr[1]) ? SIZE_WORD : SIZE_LONG))
    else $error("instruction fetch size wrong");
  chk_cycle_min_len: assert property (@(posedge i_clock) disable iff (i_rst)
    $rose(o_address_strobe_n) && !err_q |-> $past(cyc_q) >= 8'(MIN_ACK_CYCLE_CLKS - 1))
    else $error("acknowledged cycle shorter than three clocks");
  chk_no_wait_fast: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_q == ST_SAMPLE && $past(state_q) == ST_ADDR && ack_seen && !bus_error_in_s)
      |-> !o_address_strobe_n ##1 !o_address_strobe_n ##1 o_address_strobe_n)
    else $error("wait state inserted despite early acknowledge");
  chk_read_latch: assert property (@(posedge i_clock) disable iff (i_rst)
    $changed(acc_q) && !$past(o_req_ready) |-> $past(state_q) == ST_LATCH)
    else $error("read data latched outside latch state");
  chk_strobe_order: assert property (@(posedge i_clock) disable iff (i_rst)
    !o_data_strobe_n |-> !o_address_strobe_n && (o_read_write || o_data_oe))
    else $error("data strobe without address strobe or write data");
  chk_split_fits: assert property (@(posedge i_clock) disable iff (i_rst)
    state_q == ST_LATCH |-> sp.moved != 3'h0 && sp.moved <= rem_q
      && ({1'b0, sp.lane} + sp.moved) <= ((port_q == PORT_32) ? 3'h4 : (port_q == PORT_16) ? 3'h2 : 3'h1))
    else $error("partial transfer does not fit port");
  chk_abort_err: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_q == ST_END && err_q && !retry_q) |=> o_bus_err && o_done && o_req_ready)
    else $error("bus error did not abort");
  chk_retry_halt: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_q == ST_END && retry_q && halt_s) |=> o_address_strobe_n && !o_done)
    else $error("retry did not wait for halt release");
  chk_partial_next: assert property (@(posedge i_clock) disable iff (i_rst)
    (state_q == ST_LATCH && !bus_error_in_s && sp.moved < rem_q)
      |=> ##1 state_q == ST_ADDR && o_addr == $past(o_addr, 2) + 32'($past(sp.moved, 2)))
    else $error("next partial cycle not started");

  cov_long_16_odd: cover property (@(posedge i_clock) disable iff (i_rst)
    state_q == ST_LATCH && port_q == PORT_16 && rem_q == 3'h3 && addr_q[1:0] == 2'h2);
  cov_retry: cover property (@(posedge i_clock) disable iff (i_rst)
    state_q == ST_END && retry_q ##1 state_q == ST_ADDR);
  cov_wait_states: cover property (@(posedge i_clock) disable iff (i_rst)
    state_q == ST_SAMPLE && !ack_seen ##1 state_q == ST_SAMPLE ##1 state_q == ST_LATCH);
  cov_addr_err: cover property (@(posedge i_clock) disable iff (i_rst) o_addr_err);
endmodule

// >>> design/dbs_pkg.sv
// Purpose: Shared constants and types of the dynamic bus sizing master.
// Assumes: Single 20 MHz system clock, synchronous active-high reset.
// Notes:   Size codes equal the remaining byte count modulo four.
package dbs_pkg;
  // Size code driven during a partial cycle
  localparam logic [1:0] SIZE_LONG  = 2'h0;
  localparam logic [1:0] SIZE_BYTE  = 2'h1;
  localparam logic [1:0] SIZE_WORD  = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;
  // Port width learned from the acknowledge pair
  localparam logic [1:0] PORT_32 = 2'h0;
  localparam logic [1:0] PORT_16 = 2'h1;
  localparam logic [1:0] PORT_8  = 2'h2;
  // Operand byte counts
  localparam logic [2:0] BYTES_BYTE = 3'h1;
  localparam logic [2:0] BYTES_WORD = 3'h2;
  localparam logic [2:0] BYTES_LONG = 3'h4;
  // Timing
  localparam int CLK_PERIOD_NS      = 50;
  localparam int MIN_ACK_CYCLE_CLKS = 3;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_ADDR   = 3'h1,
    ST_SAMPLE = 3'h3,
    ST_LATCH  = 3'h2,
    ST_END    = 3'h6
  } dbs_state_t;
endpackage

// >>> design/dbs_split_if.sv
// Purpose: Carries one partial cycle's split decision between master and sizer.
// Assumes: Purely combinational exchange on the master's clock.
// Notes:   moved is only meaningful while remaining is non-zero.
`timescale 1ns/1ns
interface dbs_split_if;
  logic [1:0] addr_lo;
  logic [2:0] remaining;
  logic [1:0] port;
  logic [2:0] moved;
  logic [1:0] lane;
  modport master (output addr_lo, output remaining, output port, input moved, input lane);
  modport sizer  (input addr_lo, input remaining, input port, output moved, output lane);
endinterface

// >>> design/dbs_sizer.sv
// Purpose: Bytes moved by one partial cycle and the first data lane used.
// Assumes: Port width already decoded from the acknowledge pair.
// Notes:   Moves the lesser of what remains and what fits above the offset.
`timescale 1ns/1ns
module dbs_sizer
  import dbs_pkg::*;
(
  dbs_split_if.sizer sp
);
  logic [2:0] port_bytes;
  logic [2:0] offset;
  logic [2:0] room;

  always_comb begin
    case (sp.port)
      PORT_32: begin
        port_bytes = BYTES_LONG;
        offset     = {1'b0, sp.addr_lo};
      end
      PORT_16: begin
        port_bytes = BYTES_WORD;
        offset     = {2'b00, sp.addr_lo[0]};
      end
      default: begin
        port_bytes = BYTES_BYTE;
        offset     = 3'h0;
      end
    endcase
    room    = port_bytes - offset;
    sp.lane = offset[1:0];
    // Misaligned operands are split instead of refused
    sp.moved = (sp.remaining < room) ? sp.remaining : room;
  end
endmodule

// >>> testbench/dbs_slave_model.sv
// Purpose: Behavioural memory slave answering the master's strobes.
// Assumes: Acts on falling edges; 256-byte space wraps.
// Notes:   Released lanes toggle every cycle so stale data is never reused.
`timescale 1ns/1ns
module dbs_slave_model
  import dbs_pkg::*;
(
  // Master side
  input  wire logic        i_clock,
  input  wire logic [31:0] i_addr,
  input  wire logic [1:0]  i_size_code,
  input  wire logic        i_read_write,
  input  wire logic        i_address_strobe_n,
  input  wire logic        i_data_strobe_n,
  input  wire logic [31:0] i_data,
  output logic [31:0]      o_data,
  output logic             o_ack_width_hi_n,
  output logic             o_ack_width_lo_n,
  output logic             o_bus_error_in_n,
  output logic             o_halt_n,
  // Bench controls
  input  wire logic        i_quiet,
  input  wire logic [1:0]  i_port,
  input  wire logic [1:0]  i_waits,
  input  wire logic [1:0]  i_err
);
  logic [7:0] mem [256];
  logic       acking = 0;
  logic       err_used = 0;
  int         wcnt = 0;
  int         hold = 0;
  int         w;
  int         off;
  int         n;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i * 7 + 3);
    o_data = '0;
    {o_ack_width_hi_n, o_ack_width_lo_n, o_bus_error_in_n, o_halt_n} = 4'hf;
  end

  ////////////////////////////////////////////////////////////
  always @(negedge i_clock) begin
    w = 4 >> i_port;
    off = int'(i_addr[1:0]) % w;
    n = (i_size_code == SIZE_LONG) ? 4 : int'(i_size_code);
    if (n > w - off) n = w - off;
    o_data = ~o_data;
    if (i_err == 2'h0) err_used = 0;
    if (i_address_strobe_n) begin
      // Acknowledge held only until the strobes negate
      acking = 0;
      wcnt = 0;
      {o_ack_width_hi_n, o_ack_width_lo_n, o_bus_error_in_n} = 3'h7;
      if (hold > 0) hold--;
      else o_halt_n = 1;
    end else begin
      // Data valid together with acknowledge
      if (i_read_write)
        for (int k = 0; k < w; k++) o_data[31 - 8 * k -: 8] = mem[8'(int'(i_addr) - off + k)];
      // Writes wait for the data strobe before latching
      if (!acking && !i_quiet && (i_read_write || !i_data_strobe_n)) begin
        if (wcnt < int'(i_waits)) wcnt++;
        else begin
          acking = 1;
          if ((i_err == 2'h1 || i_err == 2'h2) && !err_used) begin
            // Fault replaces the acknowledge; halt asks for a retry
            err_used = 1;
            o_bus_error_in_n = 0;
            o_halt_n = (i_err != 2'h2);
            hold = 3;
          end else begin
            // Width pair timed from the system clock
            o_ack_width_hi_n = (i_port == PORT_8);
            o_ack_width_lo_n = (i_port == PORT_16);
            if (!i_read_write)
              for (int j = 0; j < n; j++)
                mem[8'(int'(i_addr) + j)] = i_data[31 - 8 * (off + j) -: 8];
          end
        end
      end else if (acking && i_err == 2'h3 && !err_used) begin
        // Late fault one clock after the acknowledge aborts the cycle
        err_used = 1;
        o_bus_error_in_n = 0;
      end
    end
  end
endmodule

// >>> testbench/dynamic_bus_sizing_handshake_tb.sv
// Purpose: Self-checking bench of the bus master against a memory slave.
// Assumes: Bench drives on falling edges; slave model stands for the far side.
// Notes:   Expected data comes from a byte model of memory; cycle splits are worked out from address, size and port.
`timescale 1ns/1ns
module dynamic_bus_sizing_handshake_tb;
  import dbs_pkg::*;
  logic        i_clock = 0;
  logic        i_rst = 1;
  logic        i_req_valid = 0, i_req_write = 0, i_req_instr = 0, i_int_ack_en = 0;
  logic [1:0]  i_req_size = '0, i_int_ack_port = '0, port = '0, waits = '0, err = '0;
  logic [31:0] i_req_addr = '0, i_req_wdata = '0, o_rdata, o_addr, o_data_out, s_data;
  logic        o_req_ready, o_done, o_bus_err, o_addr_err, o_read_write, o_data_oe;
  logic        o_address_strobe_n, o_data_strobe_n, i_ack_width_hi_n, i_ack_width_lo_n;
  logic        i_bus_error_in_n, i_halt_n, as_prev = 1;
  logic [1:0]  o_size_code;
  wire  [31:0] i_data_in = o_data_oe ? o_data_out : s_data;
  logic [7:0]  rmem [256];
  logic [4:0]  trace [$];
  logic [15:0] rnd = 16'h000d;
  int          error_cnt = 0, checked = 0, ncyc, as_len;

  always #(CLK_PERIOD_NS / 2) i_clock = ~i_clock;

  dbs_bus_master i_dut (.i_clock, .i_rst, .i_req_valid, .i_req_write, .i_req_instr, .i_req_size,
    .i_req_addr, .i_req_wdata, .o_req_ready, .o_done, .o_bus_err, .o_addr_err, .o_rdata,
    .i_int_ack_en, .i_int_ack_port, .o_addr, .o_size_code, .o_read_write, .o_address_strobe_n,
    .o_data_strobe_n, .o_data_out, .o_data_oe, .i_data_in, .i_ack_width_hi_n,
    .i_ack_width_lo_n, .i_bus_error_in_n, .i_halt_n);
  dbs_slave_model u_slave (.i_clock, .i_addr(o_addr), .i_size_code(o_size_code),
    .i_read_write(o_read_write), .i_address_strobe_n(o_address_strobe_n),
    .i_data_strobe_n(o_data_strobe_n), .i_data(i_data_in), .o_data(s_data),
    .o_ack_width_hi_n(i_ack_width_hi_n), .o_ack_width_lo_n(i_ack_width_lo_n),
    .o_bus_error_in_n(i_bus_error_in_n), .o_halt_n(i_halt_n), .i_quiet(i_int_ack_en),
    .i_port(port), .i_waits(waits), .i_err(err));

  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] rng();
    rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
    return rnd;
  endfunction

  function automatic logic [31:0] ref_rd(input int a, input int n);
    logic [31:0] v = '0;
    for (int j = 0; j < n; j++) v = {v[23:0], rmem[a + j]};
    return v;
  endfunction

  // Bus cycles per operand for ports 32:16:8, word row then long row
  function automatic int exp_cyc(input int n, input int off, input int p);
    int t [2][4][3] = '{'{'{1, 1, 2}, '{1, 2, 2}, '{1, 1, 2}, '{2, 2, 2}},
                        '{'{1, 2, 4}, '{2, 3, 4}, '{2, 2, 4}, '{2, 3, 4}}};
    if (n == 1) return 1;
    return t[n / 4][off][p];
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic run_op(input logic wr, input logic ins, input logic [1:0] sz, input int a,
                        input logic [31:0] wd, output logic [31:0] rd, output logic be,
                        output logic ae, output int cyc);
    int t = 0;
    ncyc = 0;
    trace.delete();
    @(negedge i_clock);
    {i_req_valid, i_req_write, i_req_instr, i_req_size} = {1'b1, wr, ins, sz};
    i_req_addr = 32'(a);
    i_req_wdata = wd;
    @(negedge i_clock);
    i_req_valid = 0;
    while (o_done !== 1'b1 && o_addr_err !== 1'b1 && t < 2000) begin
      @(negedge i_clock);
      t++;
    end
    if (t == 2000) begin
      chk("completion", 0, 1);
      give_verdict();
    end
    {rd, be, ae, cyc} = {o_rdata, o_bus_err, o_addr_err, ncyc};
    @(negedge i_clock);
  endtask

  // Walks the expected split: most significant byte first, address ascending
  task automatic chk_trace(input int a, input int n, input int p);
    int w = 4 >> p;
    int k = 0;
    int m;
    while (n > 0) begin
      m = (w - a % w > n) ? n : w - a % w;
      chk("cycle addr size", 32'(trace[k]), 32'({3'(a), 2'(n)}));
      a += m;
      n -= m;
      k++;
    end
  endtask

  ////////////////////////////////////////////////////////////
  always @(negedge i_clock) begin
    if (!o_address_strobe_n) begin
      if (as_prev) begin
        ncyc++;
        trace.push_back({o_addr[2:0], o_size_code});
        as_len = 0;
      end
      as_len++;
    end else if (!as_prev) chk("strobe length", 32'(as_len >= MIN_ACK_CYCLE_CLKS), 1);
    if (!o_data_strobe_n && !o_read_write) chk("write drive", 32'(o_data_oe), 1);
    as_prev = o_address_strobe_n;
  end

  initial begin
    logic [31:0] rd;
    logic        be, ae;
    int          cyc, a, n;
    for (int i = 0; i < 256; i++) rmem[i] = 8'(i * 7 + 3);
    repeat (16) @(negedge i_clock);
    chk("reset idle", 32'({o_req_ready, o_address_strobe_n, o_data_oe}), 32'h6);
    i_rst = 0;
    for (int p = 0; p < 3; p++)
      for (int s = 0; s < 3; s++)
        for (int o = 0; o < 4; o++) begin
          n = (s == 0) ? 4 : s;
          a = 8 * int'(rng() % 32) + o;
          port <= 2'(p);
          waits <= 2'(rng());
          run_op(1, 0, 2'(n), a, {rng(), rng()}, rd, be, ae, cyc);
          for (int j = 0; j < n; j++) rmem[a + j] = i_req_wdata[8 * (n - 1 - j) +: 8];
          chk("write cycles", 32'(cyc), 32'(exp_cyc(n, o, p)));
          chk_trace(a, n, p);
          run_op(0, 0, 2'(n), a, 0, rd, be, ae, cyc);
          chk("read data", rd, ref_rd(a, n));
          chk("read cycles", 32'(cyc), 32'(exp_cyc(n, o, p)));
          chk_trace(a, n, p);
        end
    $display("Sizing sweep done");
    for (int p = 0; p < 3; p++) begin
      port <= 2'(p);
      a = 8 * int'(rng() % 31);
      run_op(0, 1, 2'h0, a, 0, rd, be, ae, cyc);
      chk("fetch long", rd, ref_rd(a, 4));
      chk_trace(a, 4, p);
      run_op(0, 1, 2'h0, a + 2, 0, rd, be, ae, cyc);
      chk("fetch word", rd, ref_rd(a + 2, 2));
      run_op(0, 1, 2'h0, a + 3, 0, rd, be, ae, cyc);
      chk("odd fetch", 32'({ae, 5'(cyc)}), 32'h20);
      i_int_ack_en <= 1;
      i_int_ack_port <= 2'(p);
      run_op(0, 0, SIZE_LONG, 33, 0, rd, be, ae, cyc);
      chk("internal ack", rd, ref_rd(33, 4));
      chk("internal cycles", 32'(cyc), 32'(exp_cyc(4, 1, p)));
      i_int_ack_en <= 0;
    end
    $display("Fetch and internal acknowledge done");
    port <= PORT_16;
    err <= 2'h1;
    run_op(0, 0, SIZE_LONG, 16, 0, rd, be, ae, cyc);
    chk("abort flag", 32'(be), 1);
    err <= 2'h0;
    @(negedge i_clock);
    err <= 2'h3;
    run_op(0, 0, SIZE_LONG, 16, 0, rd, be, ae, cyc);
    chk("late abort", 32'({be, 5'(cyc)}), 32'h21);
    err <= 2'h0;
    @(negedge i_clock);
    err <= 2'h2;
    run_op(0, 0, SIZE_LONG, 16, 0, rd, be, ae, cyc);
    chk("retry data", rd, ref_rd(16, 4));
    chk("retry cycles", 32'({be, 5'(cyc)}), 32'h3);
    err <= 2'h0;
    $display("Bus error and retry done");
    give_verdict();
  end
endmodule
